// ===== common/seq_ext_params.svh
`ifndef SEQ_EXT_PARAMS_SVH
`define SEQ_EXT_PARAMS_SVH
// ==========================================
// Index and port decode
`define IDX_SCRATCH0     8'h09
`define IDX_SCRATCH1     8'h0a
`define IDX_VCLK0_NUM    8'h0b
`define IDX_VCLK1_NUM    8'h0c
`define IDX_VCLK2_NUM    8'h0d
`define IDX_VCLK3_NUM    8'h0e
`define IDX_MEM_CTRL     8'h0f
`define PORT_SEQ_INDEX   16'h03c4
`define PORT_SEQ_DATA    16'h03c5
// ==========================================
// Reset values
`define RST_SCRATCH      8'h00
`define RST_VCLK0_NUM    7'h66
`define RST_VCLK1_NUM    7'h5b
`define RST_VCLK2_NUM    7'h45
`define RST_VCLK3_NUM    7'h7e
`define RST_VCLK0_DEN    6'h3b
`define RST_VCLK1_DEN    6'h2f
`define RST_VCLK2_DEN    6'h30
`define RST_VCLK3_DEN    6'h33
`define RST_MEM_CTRL     8'h0d
// Organization shadow before the first blanking start: one bank, 32-bit width code
`define RST_ORG_SHADOW   3'h2
`define RST_INDEX        8'h00
`define RST_RDATA        8'h00
// Row-strobe cycle lengths in memory clocks
`define RAS_SHORT_CLKS   3'h6
`define RAS_LONG_CLKS    3'h7
// ==========================================
// Field positions and masks
`define NUM_MASK         8'h7f
`define MEM_CTRL_MASK    8'hfd
`define MC_BANK_BIT      7
`define MC_FPDIS_BIT     6
`define MC_FIFO_BIT      5
`define MC_WIDTH_HI      4
`define MC_WIDTH_LO      3
`define MC_RAS_BIT       2
`define MC_CAS_BIT       0
`define DEN_HI           5
`define DEN_LO           1
`define POST_BIT         0
`define MISC_SEL_HI      3
`define MISC_SEL_LO      2
// Reference oscillator in kHz
`define OSC_KHZ          14318
`endif

// ===== common/seq_ext_pkg.sv
package seq_ext_pkg;
  // ==========================================
  // Synthesizer settings for one video clock
  typedef struct packed {
    logic [6:0] numerator_value;
    logic [4:0] denominator_value;
    logic       post_scalar;
  } video_pixel_clock_setting_t;

  // Memory timing controls seen by the memory sequencer
  typedef struct packed {
    logic       two_banks;
    logic       fast_page_disable;
    logic       fifo_depth_ctl;
    logic [1:0] bus_width;
    logic       ras_six_clocks;
    logic       multi_cas;
    logic       org_valid;
  } mem_timing_t;
endpackage

// ===== rtl/seq_ext_regs.sv
`include "seq_ext_params.svh"

module seq_ext_regs #(
  parameter int OSC_KHZ = `OSC_KHZ
) (
  input  wire logic                        ref_clk,
  input  wire logic                        rst_n,
  input  wire logic [15:0]                 io_addr,
  input  wire logic                        io_wr,
  input  wire logic                        io_rd,
  input  wire logic [7:0]                  io_wdata,
  output logic [7:0]                       io_rdata,
  input  wire logic [5:0]                  clock_denominator_register [4],
  input  wire logic [1:0]                  misc_clock_select,
  input  wire logic                        hblank_start,
  output seq_ext_pkg::video_pixel_clock_setting_t       video_pixel_clock_setting,
  output logic [31:0]                      video_pixel_clock_khz,
  output seq_ext_pkg::mem_timing_t         mem_timing,
  output logic                             fast_page_allowed,
  output logic [2:0]                       ras_cycle_clocks
);

  // ==========================================
  // Register state
  logic [7:0] index_reg;
  logic [7:0] firmware_scratch_0;
  logic [7:0] firmware_scratch_1;
  logic [6:0] numerator_value [4];
  logic [7:0] memory_control_register;
  logic [2:0] org_shadow;

  logic [7:0] next_index_reg;
  logic [7:0] next_firmware_scratch_0;
  logic [7:0] next_firmware_scratch_1;
  logic [6:0] next_numerator_value [4];
  logic [7:0] next_memory_control_register;
  logic [2:0] next_org_shadow;
  logic [7:0] next_io_rdata;

  // Decoded clock setting for one clock slot
  function automatic seq_ext_pkg::video_pixel_clock_setting_t pick(input logic [6:0] num, input logic [5:0] den);
    seq_ext_pkg::video_pixel_clock_setting_t s;
    s.numerator_value   = num;
    s.denominator_value = den[`DEN_HI:`DEN_LO];
    s.post_scalar       = den[`POST_BIT];
    return s;
  endfunction

  logic data_wr;
  logic data_rd;
  assign data_wr = io_wr && (io_addr == `PORT_SEQ_DATA);
  assign data_rd = io_rd && (io_addr == `PORT_SEQ_DATA);

  // ==========================================
  // Index latch, register writes and read mux
  always_comb begin
    next_index_reg               = index_reg;
    next_firmware_scratch_0      = firmware_scratch_0;
    next_firmware_scratch_1      = firmware_scratch_1;
    next_numerator_value         = numerator_value;
    next_memory_control_register = memory_control_register;
    next_io_rdata                = io_rdata;
    if (io_wr && io_addr == `PORT_SEQ_INDEX) begin
      next_index_reg = io_wdata;
    end
    if (data_wr) begin
      case (index_reg)
        `IDX_SCRATCH0:  next_firmware_scratch_0 = io_wdata;
        `IDX_SCRATCH1:  next_firmware_scratch_1 = io_wdata;
        `IDX_VCLK0_NUM: next_numerator_value[0] = io_wdata[6:0];
        `IDX_VCLK1_NUM: next_numerator_value[1] = io_wdata[6:0];
        `IDX_VCLK2_NUM: next_numerator_value[2] = io_wdata[6:0];
        `IDX_VCLK3_NUM: next_numerator_value[3] = io_wdata[6:0];
        `IDX_MEM_CTRL:  next_memory_control_register = io_wdata & `MEM_CTRL_MASK;
        default: begin
        end
      endcase
    end
    // Reads return registered data; unmapped indexes read zero
    if (io_rd && io_addr == `PORT_SEQ_INDEX) begin
      next_io_rdata = index_reg;
    end else if (data_rd) begin
      case (index_reg)
        `IDX_SCRATCH0:  next_io_rdata = firmware_scratch_0;
        `IDX_SCRATCH1:  next_io_rdata = firmware_scratch_1;
        `IDX_VCLK0_NUM: next_io_rdata = {1'b0, numerator_value[0]};
        `IDX_VCLK1_NUM: next_io_rdata = {1'b0, numerator_value[1]};
        `IDX_VCLK2_NUM: next_io_rdata = {1'b0, numerator_value[2]};
        `IDX_VCLK3_NUM: next_io_rdata = {1'b0, numerator_value[3]};
        `IDX_MEM_CTRL:  next_io_rdata = memory_control_register;
        default:        next_io_rdata = 8'h00;
      endcase
    end
  end

  always_comb begin
    next_org_shadow = org_shadow;
    if (hblank_start) begin
      next_org_shadow = {memory_control_register[`MC_BANK_BIT],
                         memory_control_register[`MC_WIDTH_HI],
                         memory_control_register[`MC_WIDTH_LO]};
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      index_reg               <= `RST_INDEX;
      firmware_scratch_0      <= `RST_SCRATCH;
      firmware_scratch_1      <= `RST_SCRATCH;
      numerator_value[0]      <= `RST_VCLK0_NUM;
      numerator_value[1]      <= `RST_VCLK1_NUM;
      numerator_value[2]      <= `RST_VCLK2_NUM;
      numerator_value[3]      <= `RST_VCLK3_NUM;
      memory_control_register <= `RST_MEM_CTRL;
      org_shadow              <= `RST_ORG_SHADOW;
      io_rdata                <= `RST_RDATA;
    end else begin
      index_reg               <= next_index_reg;
      firmware_scratch_0      <= next_firmware_scratch_0;
      firmware_scratch_1      <= next_firmware_scratch_1;
      numerator_value         <= next_numerator_value;
      memory_control_register <= next_memory_control_register;
      org_shadow              <= next_org_shadow;
      io_rdata                <= next_io_rdata;
    end
  end

  // ==========================================
  // Clock selection and frequency estimate
  seq_ext_pkg::video_pixel_clock_setting_t sel_setting;
  logic [31:0]                freq_calc;
  logic [31:0]                divisor;
  always_comb begin
    sel_setting = pick(numerator_value[misc_clock_select], clock_denominator_register[misc_clock_select]);
    divisor = 32'(sel_setting.denominator_value) * 32'({1'b0, sel_setting.post_scalar} + 2'h1);
    freq_calc = (divisor == 32'h0) ? 32'h0 : (32'(OSC_KHZ) * 32'(sel_setting.numerator_value)) / divisor;
  end

  // Outputs registered so timing logic sees stable values
  seq_ext_pkg::mem_timing_t next_mem_timing;
  always_comb begin
    next_mem_timing.two_banks         = org_shadow[2];
    next_mem_timing.fast_page_disable = memory_control_register[`MC_FPDIS_BIT];
    next_mem_timing.fifo_depth_ctl    = memory_control_register[`MC_FIFO_BIT];
    next_mem_timing.bus_width         = org_shadow[1:0];
    next_mem_timing.ras_six_clocks    = memory_control_register[`MC_RAS_BIT];
    next_mem_timing.multi_cas         = memory_control_register[`MC_CAS_BIT];
    next_mem_timing.org_valid         = (org_shadow[1:0] == 2'b10);
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      video_pixel_clock_setting <= '0;
      video_pixel_clock_khz     <= 32'h0;
      mem_timing                <= '0;
      fast_page_allowed         <= 1'b0;
      ras_cycle_clocks          <= 3'h0;
    end else begin
      video_pixel_clock_setting <= sel_setting;
      video_pixel_clock_khz     <= freq_calc;
      mem_timing                <= next_mem_timing;
      fast_page_allowed         <= !next_mem_timing.fast_page_disable;
      ras_cycle_clocks          <= next_mem_timing.ras_six_clocks ? `RAS_SHORT_CLKS : `RAS_LONG_CLKS;
    end
  end

endmodule

// ===== dv/seq_ext_regs_asserts.sv
module seq_ext_regs_asserts #(
  parameter int OSC_KHZ = 14318
) (
  input wire logic                       ref_clk,
  input wire logic                       rst_n,
  input wire logic [15:0]                io_addr,
  input wire logic                       io_wr,
  input wire logic                       io_rd,
  input wire logic [7:0]                 io_wdata,
  input wire logic [7:0]                 io_rdata,
  input wire logic [5:0]                 clock_denominator_register [4],
  input wire logic [1:0]                 misc_clock_select,
  input wire logic                       hblank_start,
  input wire seq_ext_pkg::video_pixel_clock_setting_t video_pixel_clock_setting,
  input wire logic [31:0]                video_pixel_clock_khz,
  input wire seq_ext_pkg::mem_timing_t   mem_timing,
  input wire logic                       fast_page_allowed,
  input wire logic [2:0]                 ras_cycle_clocks
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]                 idx;
  logic [1:0]                 age;
  logic                       ok;
  logic                       mc_wr;
  seq_ext_pkg::video_pixel_clock_setting_t vs;
  // ==========================================
  // Index copy and settle age, so past values never reach back into reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      idx <= 8'h00;
      age <= 2'h0;
    end else begin
      if (io_wr && io_addr == 16'h03c4) idx <= io_wdata;
      if (age != 2'h3) age <= age + 2'h1;
    end
  end
  assign ok = age == 2'h3;
  assign mc_wr = io_wr && io_addr == 16'h03c5 && idx == 8'h0f;
  assign vs = video_pixel_clock_setting;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  // ==========================================
  // Properties
  ras_length_a: assert property (ok |-> ras_cycle_clocks == (mem_timing.ras_six_clocks ? 3'h6 : 3'h7))
    else $error("ras length wrong");
  fast_page_a: assert property (ok |-> fast_page_allowed == !mem_timing.fast_page_disable)
    else $error("fast page flag wrong");
  unmapped_read_a: assert property (io_rd && io_addr == 16'h03c5 && (idx < 8'h09 || idx > 8'h0f)
    |=> io_rdata == 8'h00) else $error("unmapped read not zero");
  fpd_write_a: assert property (mc_wr |-> ##2 fast_page_allowed == !$past(io_wdata[6], 2))
    else $error("fast page not from write");
  timing_write_a: assert property (mc_wr |-> ##2 {mem_timing.ras_six_clocks, mem_timing.multi_cas}
    == {$past(io_wdata[2], 2), $past(io_wdata[0], 2)}) else $error("timing bits not from write");
  org_shadow_a: assert property (ok && ($changed(mem_timing.two_banks) || $changed(mem_timing.bus_width))
    |-> $past(hblank_start, 2)) else $error("organization moved outside blanking");
  clock_pick_a: assert property (ok && $stable(misc_clock_select) |-> {vs.denominator_value, vs.post_scalar}
    == clock_denominator_register[misc_clock_select]) else $error("clock pick wrong");
  khz_calc_a: assert property (ok && $stable(vs) && vs.denominator_value != 5'h00
    |-> video_pixel_clock_khz == 32'(OSC_KHZ * vs.numerator_value / (vs.denominator_value * (vs.post_scalar + 1))))
    else $error("clock rate wrong");
endmodule

bind seq_ext_regs seq_ext_regs_asserts #(.OSC_KHZ(OSC_KHZ)) chk_i (.ref_clk(ref_clk), .rst_n(rst_n),
  .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
  .clock_denominator_register(clock_denominator_register), .misc_clock_select(misc_clock_select),
  .hblank_start(hblank_start), .video_pixel_clock_setting(video_pixel_clock_setting),
  .video_pixel_clock_khz(video_pixel_clock_khz), .mem_timing(mem_timing),
  .fast_page_allowed(fast_page_allowed), .ras_cycle_clocks(ras_cycle_clocks));

// ===== dv/seq_ext_regs_test.sv
`include "seq_ext_params.svh"
module seq_ext_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic                       ref_clk = 1'b0;
  logic                       rst_n = 1'b0;
  logic [15:0]                io_addr = 16'h0000;
  logic                       io_wr = 1'b0;
  logic                       io_rd = 1'b0;
  logic [7:0]                 io_wdata = 8'h00;
  logic [7:0]                 io_rdata;
  logic [5:0]                 den [4] = '{`RST_VCLK0_DEN, `RST_VCLK1_DEN, `RST_VCLK2_DEN, `RST_VCLK3_DEN};
  logic [1:0]                 sel = 2'h0;
  logic                       hblank_start = 1'b0;
  seq_ext_pkg::video_pixel_clock_setting_t vset;
  logic [31:0]                khz;
  seq_ext_pkg::mem_timing_t   mt;
  logic                       fpa;
  logic [2:0]                 ras;
  logic [6:0]                 num [4] = '{7'h66, 7'h5b, 7'h45, 7'h7e};
  logic [7:0]                 rstv [7] = '{8'h00, 8'h00, 8'h66, 8'h5b, 8'h45, 8'h7e, 8'h0d};
  logic [7:0]                 mask [7] = '{8'hff, 8'hff, 8'h7f, 8'h7f, 8'h7f, 8'h7f, 8'hfd};
  int                         num_errors = 0;
  int                         checked = 0;
  // ==========================================
  // Clock and device
  always #10 ref_clk = ~ref_clk;
  seq_ext_regs uut (.ref_clk(ref_clk), .rst_n(rst_n), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .clock_denominator_register(den), .misc_clock_select(sel),
    .hblank_start(hblank_start), .video_pixel_clock_setting(vset), .video_pixel_clock_khz(khz),
    .mem_timing(mt), .fast_page_allowed(fpa), .ras_cycle_clocks(ras));
  // ==========================================
  // Port access tasks; strobes stay up between calls so no edge sees a double drive
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    io_addr = a;
    io_wdata = d;
    io_rd = 1'b0;
    io_wr = 1'b1;
  endtask
  task automatic wx(input logic [7:0] i, input logic [7:0] d);
    wr(`PORT_SEQ_INDEX, i);
    wr(`PORT_SEQ_DATA, d);
    @(negedge ref_clk);
    io_wr = 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic rchk(input logic [7:0] i, input logic [7:0] e, input string what);
    wr(`PORT_SEQ_INDEX, i);
    @(negedge ref_clk);
    io_addr = `PORT_SEQ_DATA;
    io_wr = 1'b0;
    io_rd = 1'b1;
    @(negedge ref_clk);
    io_rd = 1'b0;
    @(negedge ref_clk);
    chk(what, io_rdata, e);
  endtask
  // Walk all four clock selects; rate is worked out here from the stored fields
  task automatic clocks();
    int d;
    for (int s = 0; s < 4; s++) begin
      @(negedge ref_clk);
      sel = 2'(s);
      repeat (3) @(negedge ref_clk);
      d = den[s][5:1] * (den[s][0] + 1);
      chk("numerator", vset.numerator_value, num[s]);
      chk("denominator", {vset.denominator_value, vset.post_scalar}, den[s]);
      chk("rate", khz, `OSC_KHZ * num[s] / d);
    end
  endtask
  task automatic conclude();
    $display("checked %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ==========================================
  // Main sequence
  initial begin
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    rst_n = 1'b1;
    for (int i = 0; i < 7; i++) rchk(8'(9 + i), rstv[i], "reset value");
    chk("reset timing", {fpa, ras, mt.two_banks, mt.bus_width, mt.multi_cas}, 8'b1110_0101);
    clocks();
    $display("test reset done");
    // Write ones everywhere; reserved bits must read back zero
    for (int i = 0; i < 7; i++) begin
      wx(8'(9 + i), 8'hff);
      rchk(8'(9 + i), mask[i], "write ones");
    end
    for (int s = 0; s < 4; s++) num[s] = 7'h7f;
    clocks();
    wx(8'h08, 8'h5a);
    rchk(8'h08, 8'h00, "unmapped low");
    wx(8'h10, 8'h5a);
    rchk(8'h10, 8'h00, "unmapped high");
    chk("org held", {fpa, mt.two_banks, mt.bus_width}, 4'b0010);
    chk("fifo and valid", {mt.fifo_depth_ctl, mt.org_valid}, 2'b11);
    // Index port reads back the last index written
    @(negedge ref_clk);
    io_addr = `PORT_SEQ_INDEX;
    io_rd = 1'b1;
    @(negedge ref_clk);
    io_rd = 1'b0;
    @(negedge ref_clk);
    chk("index readback", io_rdata, 8'h10);
    $display("test access done");
    // Bank and width wait for blanking; the other bits act at once
    wx(8'h0f, 8'h90);
    chk("fast ras cas", {fpa, ras, mt.multi_cas}, 5'b1_111_0);
    chk("org before blank", {mt.two_banks, mt.bus_width}, 3'b010);
    hblank_start = 1'b1;
    @(negedge ref_clk);
    hblank_start = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk("org after blank", {mt.two_banks, mt.bus_width}, 3'b110);
    wx(8'h0f, 8'h45);
    chk("fast ras cas", {fpa, ras, mt.multi_cas}, 5'b0_110_1);
    chk("disable fifo valid", {mt.fast_page_disable, mt.fifo_depth_ctl, mt.org_valid}, 3'b101);
    $display("test memory control done");
    conclude();
  end
  // Watchdog for a hung run
  initial begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    conclude();
  end
endmodule
